// File: core/cvc_regs.svh
// register map, field positions, reset values and select codes of the clock control block
// assumes a 32-bit apb slave with byte addresses and one register per aligned word
`ifndef CVC_REGS_SVH
`define CVC_REGS_SVH

// byte offsets
`define CVC_RANGE_OFS     12'h000
`define CVC_CLK_OFS       12'h004
`define CVC_MEM_OFS       12'h008
`define CVC_FLASH_OFS     12'h00C
`define CVC_RST_OFS       12'h010
`define CVC_STAT_OFS      12'h014

// range control register fields
`define CVC_RANGE_LSB     0
`define CVC_REGDIS_BIT    2
// clock control register fields
`define CVC_SEL_LSB       0
`define CVC_PSC_LSB       6
`define CVC_RDY_BIT       13
`define CVC_HFEN_BIT      16
`define CVC_XTEN_BIT      17
`define CVC_RINGEN_BIT    18
`define CVC_HFRDY_BIT     24
`define CVC_XTRDY_BIT     25
`define CVC_RINGRDY_BIT   26
// memory control, flash control and reset trigger fields
`define CVC_FWS_LSB       0
`define CVC_LVE_BIT       0
`define CVC_PRST_BIT      0
// status register fields
`define CVC_ACTSEL_LSB    0
`define CVC_FLBUSY_BIT    4

// values
`define CVC_RANGE_RSV     2'h3
`define CVC_FWS_RST       3'h5
`define CVC_PSC_RST       3'h1
`define CVC_SEL_HF        2'h0
`define CVC_SEL_RING      2'h1
`define CVC_SEL_XTAL      2'h2

`endif

// File: core/cvc_pkg.sv
// types shared by the clock control block
// assumes cvc_regs.svh supplies the field layout
package cvc_pkg;

  // oscillator switchover sequencer
  typedef enum logic [0:0] {
    CVC_SW_IDLE,
    CVC_SW_WAIT
  } cvc_sw_t;

  // complete state of the top module
  typedef struct packed {
    logic [1:0]  range;
    logic        reg_dis;
    logic [1:0]  sel_req;
    logic [1:0]  sel_act;
    logic        clk_rdy;
    logic [2:0]  psc;
    logic        hf_en;
    logic        xt_en;
    logic [2:0]  fws;
    logic        lve;
    logic        prst;
    cvc_sw_t     sw;
    logic [2:0]  osc_prev;
    logic        rtc_en;
    logic        fl_busy;
    logic [2:0]  fl_cnt;
    logic        fl_ack;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } cvc_state_t;

endpackage : cvc_pkg

// File: core/cvc_sync.sv
// two-flop synchroniser for a group of asynchronous pin levels
// assumes each bit is an independent level; no bus coherence
`timescale 1ns/1ps
module cvc_sync #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cvc_sync_st_t;

  cvc_sync_st_t st_r;
  cvc_sync_st_t st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule : cvc_sync

// File: core/cvc_presc.sv
// power-of-two prescaler: turns source ticks into system and peripheral clock enables
// assumes src_tick is a one-cycle pulse per source oscillator period
`timescale 1ns/1ps
module cvc_presc (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       src_tick,
  input  wire logic [2:0] psc,
  input  wire logic       restart,
  output logic            sys_en,
  output logic            pclk_en
);

  typedef struct packed {
    logic [6:0] cnt;
    logic       half;
    logic       sys_en;
    logic       pclk_en;
  } cvc_presc_st_t;

  cvc_presc_st_t st_r;
  cvc_presc_st_t st_nxt;
  logic [6:0]    last;

  // divisor is 2**psc, so the terminal count is 2**psc - 1
  assign last = 7'((8'h01 << psc) - 8'h01);

  always_comb begin
    st_nxt         = st_r;
    st_nxt.sys_en  = 1'b0;
    st_nxt.pclk_en = 1'b0;
    if (restart) begin
      st_nxt.cnt = '0; // new source starts a fresh divide period
    end else if (src_tick) begin
      if (st_r.cnt >= last) begin
        st_nxt.cnt     = '0;
        st_nxt.sys_en  = 1'b1;
        st_nxt.half    = ~st_r.half;
        st_nxt.pclk_en = st_r.half; // every second system tick
      end else begin
        st_nxt.cnt = st_r.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sys_en  = st_r.sys_en;
  assign pclk_en = st_r.pclk_en;

endmodule : cvc_presc

// File: core/cvc_top.sv
// core voltage range and system clock control with an apb register slave
// assumes oscillator outputs and ready flags arrive as asynchronous pins,
// the other reset requests come as one-cycle pulses from logic on clk,
// and rst is the power-on reset
//
// Notes on behaviour
// - voltage range kept through every reset except power-on
// - regulator level and fast oscillator frequency follow the range together
// - range 0, 1, 2 select 24, 48, 96 MHz at once
// - power-on, system and watchdog resets load wait states with 5
// - each flash access lasts the programmed number of system clock cycles
// - three selectable sources; select 0 is the fast oscillator
// - system clock is the source divided by two to the prescaler
// - bus clock equals system clock, peripheral clock is half of it
// - real-time clock always runs from the 32.768 kHz oscillator
// - hard resets enable the fast oscillator; soft ones keep oscillator settings
// - ring oscillator always on; 32 kHz oscillator cleared only at power-on
// - hard resets set select 0 and prescaler 1; soft ones keep them
// - new select clears ready; old source clocks until switchover completes
// - select naming a not-ready oscillator is refused
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "cvc_regs.svh"
module cvc_top
  import cvc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // reset requests from the reset controller
  input  wire logic        sys_rst_req,
  input  wire logic        wdt_rst_req,
  input  wire logic        soft_rst_req,
  // oscillator pins
  input  wire logic        fast_osc_clk,
  input  wire logic        ring_osc_clk,
  input  wire logic        xtal_osc_clk,
  input  wire logic        fast_osc_ready,
  input  wire logic        xtal_osc_ready,
  // flash access handshake
  input  wire logic        flash_req,
  output logic             flash_ack,
  // analogue controls
  output logic      [1:0]  voltage_range_field,
  output logic             regulator_disable_bit,
  output logic      [1:0]  regulator_level,
  output logic      [1:0]  fast_osc_freq_sel,
  output logic             fast_osc_enable,
  output logic             ring_osc_enable,
  output logic             xtal_osc_enable,
  output logic      [2:0]  flash_wait_state_field,
  output logic             flash_low_voltage_enable,
  output logic             peripheral_reset_pulse,
  // clock enables
  output logic             sys_clk_en,
  output logic             hclk_en,
  output logic             pclk_en,
  output logic             rtc_clk_en
);

  cvc_state_t st_r;
  cvc_state_t st_nxt;

  logic [4:0]  pin_s;
  logic [2:0]  osc_lvl;
  logic [2:0]  osc_tick;
  logic [2:0]  osc_rdy;
  logic        src_tick;
  logic        hard_rst;
  logic        setup;
  logic        wr_acc;
  logic        mapped;
  logic [1:0]  wr_sel;
  logic [1:0]  wr_rng;
  logic [31:0] rd_word;
  logic        sw_done;
  logic        presc_sys;
  logic        presc_pclk;

  // every pin level passes two flops before use
  cvc_sync #(
    .W (5)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({xtal_osc_ready, fast_osc_ready, xtal_osc_clk, ring_osc_clk, fast_osc_clk}),
    .q   (pin_s)
  );

  // source ticks by select code; ring oscillator never drops its ready
  assign osc_lvl  = pin_s[2:0];
  assign osc_tick = osc_lvl & ~st_r.osc_prev;
  assign osc_rdy  = {pin_s[4], 1'b1, pin_s[3]};

  // old source keeps driving the divider until the switchover lands
  assign src_tick = osc_tick[st_r.sel_act];

  cvc_presc u_presc (
    .clk      (clk),
    .rst      (rst),
    .src_tick (src_tick),
    .psc      (st_r.psc),
    .restart  (sw_done),
    .sys_en   (presc_sys),
    .pclk_en  (presc_pclk)
  );

  // bus decode
  assign hard_rst = sys_rst_req | wdt_rst_req;
  assign setup    = psel & ~penable;
  assign wr_acc   = psel & penable & st_r.pready & pwrite;
  assign wr_sel   = pwdata[`CVC_SEL_LSB +: 2];
  assign wr_rng   = pwdata[`CVC_RANGE_LSB +: 2];
  assign sw_done  = (st_r.sw == CVC_SW_WAIT) && osc_tick[st_r.sel_req];

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      `CVC_RANGE_OFS,
      `CVC_CLK_OFS,
      `CVC_MEM_OFS,
      `CVC_FLASH_OFS,
      `CVC_RST_OFS,
      `CVC_STAT_OFS: mapped = 1'b1;
      default:       mapped = 1'b0;
    endcase
  end

  // read mux; trigger register reads as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      `CVC_RANGE_OFS: begin
        rd_word[`CVC_RANGE_LSB +: 2] = st_r.range;
        rd_word[`CVC_REGDIS_BIT]     = st_r.reg_dis;
      end
      `CVC_CLK_OFS: begin
        rd_word[`CVC_SEL_LSB +: 2] = st_r.sel_req;
        rd_word[`CVC_PSC_LSB +: 3] = st_r.psc;
        rd_word[`CVC_RDY_BIT]      = st_r.clk_rdy;
        rd_word[`CVC_HFEN_BIT]     = st_r.hf_en;
        rd_word[`CVC_XTEN_BIT]     = st_r.xt_en;
        rd_word[`CVC_RINGEN_BIT]   = 1'b1;
        rd_word[`CVC_HFRDY_BIT]    = osc_rdy[`CVC_SEL_HF];
        rd_word[`CVC_XTRDY_BIT]    = osc_rdy[`CVC_SEL_XTAL];
        rd_word[`CVC_RINGRDY_BIT]  = osc_rdy[`CVC_SEL_RING];
      end
      `CVC_MEM_OFS: begin
        rd_word[`CVC_FWS_LSB +: 3] = st_r.fws;
      end
      `CVC_FLASH_OFS: begin
        rd_word[`CVC_LVE_BIT] = st_r.lve;
      end
      `CVC_STAT_OFS: begin
        rd_word[`CVC_ACTSEL_LSB +: 2] = st_r.sel_act;
        rd_word[`CVC_FLBUSY_BIT]      = st_r.fl_busy;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // next state
  always_comb begin
    st_nxt          = st_r;
    st_nxt.osc_prev = osc_lvl;
    st_nxt.prst     = 1'b0;
    st_nxt.fl_ack   = 1'b0;
    st_nxt.rtc_en   = osc_tick[`CVC_SEL_XTAL];

    // apb: zero-wait access, data captured in setup
    st_nxt.pready  = setup;
    st_nxt.pslverr = setup & ~mapped;
    if (setup) begin
      st_nxt.prdata = pwrite ? 32'h0000_0000 : rd_word;
    end

    // switchover finishes on the first edge of the new source
    if (sw_done) begin
      st_nxt.sel_act = st_r.sel_req;
      st_nxt.clk_rdy = 1'b1;
      st_nxt.sw      = CVC_SW_IDLE;
    end

    if (wr_acc) begin
      case (paddr)
        `CVC_RANGE_OFS: begin
          st_nxt.reg_dis = pwdata[`CVC_REGDIS_BIT];
          // reserved code leaves range, regulator and oscillator alone
          if (wr_rng != `CVC_RANGE_RSV) begin
            st_nxt.range = wr_rng;
          end
        end
        `CVC_CLK_OFS: begin
          st_nxt.psc   = pwdata[`CVC_PSC_LSB +: 3];
          st_nxt.hf_en = pwdata[`CVC_HFEN_BIT];
          st_nxt.xt_en = pwdata[`CVC_XTEN_BIT];
          // refuse unready or undefined sources; same source is no change
          if (wr_sel != `CVC_RANGE_RSV && osc_rdy[wr_sel] && wr_sel != st_nxt.sel_req) begin
            st_nxt.sel_req = wr_sel;
            st_nxt.clk_rdy = 1'b0;
            st_nxt.sw      = CVC_SW_WAIT;
          end
        end
        `CVC_MEM_OFS: begin
          st_nxt.fws = pwdata[`CVC_FWS_LSB +: 3];
        end
        `CVC_FLASH_OFS: begin
          st_nxt.lve = pwdata[`CVC_LVE_BIT];
        end
        `CVC_RST_OFS: begin
          st_nxt.prst = pwdata[`CVC_PRST_BIT];
        end
        default: ;
      endcase
    end

    // flash access spends fws system clock cycles
    if (st_r.fl_busy) begin
      if (st_r.fl_cnt == 3'h0) begin
        st_nxt.fl_busy = 1'b0;
        st_nxt.fl_ack  = 1'b1;
      end else if (presc_sys) begin
        st_nxt.fl_cnt = st_r.fl_cnt - 3'h1;
      end
    end else if (flash_req) begin
      st_nxt.fl_busy = 1'b1;
      st_nxt.fl_cnt  = st_r.fws;
    end

    // system and watchdog resets restore clock settings, not the range;
    // soft reset deliberately touches nothing here
    if (hard_rst) begin
      st_nxt.fws     = `CVC_FWS_RST;
      st_nxt.hf_en   = 1'b1;
      st_nxt.sel_req = `CVC_SEL_HF;
      st_nxt.sel_act = `CVC_SEL_HF;
      st_nxt.clk_rdy = 1'b1;
      st_nxt.sw      = CVC_SW_IDLE;
      st_nxt.psc     = `CVC_PSC_RST;
      st_nxt.lve     = 1'b0;
      st_nxt.fl_busy = 1'b0;
    end
  end

  // power-on reset is the only one that clears range and crystal enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r         <= '0;
      st_r.fws     <= `CVC_FWS_RST;
      st_r.psc     <= `CVC_PSC_RST;
      st_r.hf_en   <= 1'b1;
      st_r.clk_rdy <= 1'b1;
      st_r.sw      <= CVC_SW_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs, all from flops; soft_rst_req is accepted but changes nothing
  assign prdata                   = st_r.prdata;
  assign pready                   = st_r.pready;
  assign pslverr                  = st_r.pslverr;
  assign voltage_range_field      = st_r.range;
  assign regulator_disable_bit    = st_r.reg_dis;
  assign regulator_level          = st_r.range;
  assign fast_osc_freq_sel        = st_r.range;
  assign fast_osc_enable          = st_r.hf_en;
  assign ring_osc_enable          = st_r.osc_prev[`CVC_SEL_RING] | 1'b1;
  assign xtal_osc_enable          = st_r.xt_en;
  assign flash_wait_state_field   = st_r.fws;
  assign flash_low_voltage_enable = st_r.lve;
  assign peripheral_reset_pulse   = st_r.prst;
  assign flash_ack                = st_r.fl_ack;
  assign sys_clk_en               = presc_sys;
  assign hclk_en                  = presc_sys;
  assign pclk_en                  = presc_pclk;
  assign rtc_clk_en               = st_r.rtc_en;

endmodule : cvc_top

// File: bench/cvc_properties.sv
// concurrent checks on the ports of the clock control block
// assumes binding to cvc_top; rst is the only reset of the single clock
`timescale 1ns/1ps
module cvc_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       sys_rst_req,
  input wire logic       wdt_rst_req,
  input wire logic       soft_rst_req,
  input wire logic [1:0] voltage_range_field,
  input wire logic [1:0] regulator_level,
  input wire logic [1:0] fast_osc_freq_sel,
  input wire logic       fast_osc_enable,
  input wire logic       ring_osc_enable,
  input wire logic       xtal_osc_enable,
  input wire logic [2:0] flash_wait_state_field,
  input wire logic       flash_ack,
  input wire logic       peripheral_reset_pulse,
  input wire logic       sys_clk_en,
  input wire logic       hclk_en,
  input wire logic       pclk_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic hard;
  logic wr;
  // hard reset request and an apb access edge, which may legally move settings
  assign hard = sys_rst_req | wdt_rst_req;
  assign wr   = psel & penable;

  AST_RANGE_TRACK: assert property (regulator_level == voltage_range_field && fast_osc_freq_sel == voltage_range_field)
    else $error("regulator or oscillator frequency apart from range");
  AST_RANGE_RSV: assert property (voltage_range_field != 2'h3)
    else $error("reserved range stored");
  AST_RING_ON: assert property (ring_osc_enable)
    else $error("ring oscillator off");
  AST_HARD_LOAD: assert property (hard |=> flash_wait_state_field == 3'h5 && fast_osc_enable)
    else $error("hard reset did not load wait states or fast enable");
  AST_HARD_KEEP: assert property (hard && !wr |=> $stable(voltage_range_field) && $stable(xtal_osc_enable))
    else $error("hard reset disturbed range or crystal enable");
  AST_SOFT_KEEP: assert property (soft_rst_req && !hard && !wr |=> $stable(flash_wait_state_field))
    else $error("soft reset changed a setting");
  AST_HCLK: assert property (hclk_en == sys_clk_en)
    else $error("bus clock differs from system clock");
  AST_PCLK: assert property (pclk_en |-> sys_clk_en ##1 !pclk_en)
    else $error("peripheral clock not a sub-rate of system clock");
  AST_ACK_ONE: assert property (flash_ack |=> !flash_ack)
    else $error("flash ack longer than one cycle");
  AST_PRST_ONE: assert property (peripheral_reset_pulse |=> !peripheral_reset_pulse)
    else $error("peripheral reset pulse too long");
  AST_PREADY: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
endmodule : cvc_chk

bind cvc_top cvc_chk i_cvc_chk (.clk, .rst, .psel, .penable, .pready, .sys_rst_req, .wdt_rst_req, .soft_rst_req,
  .voltage_range_field, .regulator_level, .fast_osc_freq_sel, .fast_osc_enable, .ring_osc_enable,
  .xtal_osc_enable, .flash_wait_state_field, .flash_ack, .peripheral_reset_pulse, .sys_clk_en, .hclk_en, .pclk_en);

// File: bench/tb_top.sv
// self-checking bench for the clock control block, driven over apb
// assumes oscillator pins are slow levels made here from clk; cvc_chk is bound
`timescale 1ns/1ps
`include "cvc_regs.svh"
module tb_top;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic        sys_rst_req = 0, wdt_rst_req = 0, soft_rst_req = 0, flash_req = 0, flash_ack;
  logic        fast_osc_clk = 0, ring_osc_clk = 0, xtal_osc_clk = 0, fast_osc_ready = 1, xtal_osc_ready = 0;
  logic        regulator_disable_bit, fast_osc_enable, ring_osc_enable, xtal_osc_enable;
  logic        flash_low_voltage_enable, peripheral_reset_pulse, sys_clk_en, hclk_en, pclk_en, rtc_clk_en;
  logic [1:0]  voltage_range_field, regulator_level, fast_osc_freq_sel;
  logic [2:0]  flash_wait_state_field;
  int          n_errors = 0, check_count = 0, n_prst = 0, oc = 0, ns, np, nr, nw;

  cvc_top i_cvc_top (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sys_rst_req, .wdt_rst_req, .soft_rst_req, .fast_osc_clk, .ring_osc_clk, .xtal_osc_clk, .fast_osc_ready,
    .xtal_osc_ready, .flash_req, .flash_ack, .voltage_range_field, .regulator_disable_bit, .regulator_level,
    .fast_osc_freq_sel, .fast_osc_enable, .ring_osc_enable, .xtal_osc_enable, .flash_wait_state_field,
    .flash_low_voltage_enable, .peripheral_reset_pulse, .sys_clk_en, .hclk_en, .pclk_en, .rtc_clk_en);

  always #50 clk = ~clk;
  // oscillators: periods 8, 12, 10 clocks, slower than clk/4 as the synchroniser needs
  always @(posedge clk) begin
    oc <= oc + 1;
    if (oc % 4 == 3) fast_osc_clk <= ~fast_osc_clk;
    if (oc % 6 == 5) ring_osc_clk <= ~ring_osc_clk;
    if (oc % 5 == 4) xtal_osc_clk <= ~xtal_osc_clk;
    if (peripheral_reset_pulse) n_prst <= n_prst + 1;
  end

  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask : chk
  task chk_in(input string nm, input int lo, input int hi, input int g);
    check_count++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask : chk_in
  // one apb transfer; read data and error taken at the edge where pready is seen
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask : xfer
  task wait_rdy;
    int n;
    n = 0;
    do begin
      xfer(`CVC_CLK_OFS, 0, 0);
      n++;
    end while (q[`CVC_RDY_BIT] !== 1'b1 && n < 50);
  endtask : wait_rdy
  task pulse(input int k);
    @(posedge clk);
    sys_rst_req <= k == 0; wdt_rst_req <= k == 1; soft_rst_req <= k == 2;
    @(posedge clk);
    sys_rst_req <= 0; wdt_rst_req <= 0; soft_rst_req <= 0;
    @(posedge clk);
  endtask : pulse
  task cnt(input int c);
    ns = 0; np = 0; nr = 0;
    repeat (c) begin
      @(posedge clk);
      ns += sys_clk_en; np += pclk_en; nr += rtc_clk_en;
    end
  endtask : cnt
  task test_done;
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    // ready pins need two flops before the ready bits read true
    repeat (2) @(posedge clk);
    xfer(`CVC_CLK_OFS, 0, 0); chk("clk reset", 32'h0505_2040, q);
    xfer(`CVC_MEM_OFS, 0, 0); chk("fws reset", 32'h0000_0005, q);
    xfer(`CVC_RANGE_OFS, 0, 0); chk("range reset", 32'h0000_0000, q);
    // range change in the fixed order: regulator on, slow source, 5 wait states, range, low-voltage bit
    xfer(`CVC_RANGE_OFS, 1, 32'h0000_0000);
    xfer(`CVC_CLK_OFS, 1, 32'h0001_0041); wait_rdy;
    xfer(`CVC_MEM_OFS, 1, 32'h0000_0005);
    xfer(`CVC_RANGE_OFS, 1, 32'h0000_0002); chk("range out", 2'h2, voltage_range_field);
    chk("regulator", 2'h2, regulator_level);
    chk("osc freq", 2'h2, fast_osc_freq_sel);
    xfer(`CVC_FLASH_OFS, 1, 32'h0000_0000);
    xfer(`CVC_CLK_OFS, 1, 32'h0001_0040); wait_rdy;
    xfer(`CVC_MEM_OFS, 1, 32'h0000_0004);
    xfer(`CVC_CLK_OFS, 1, 32'h0001_0000);
    xfer(`CVC_RST_OFS, 1, 32'h0000_0001);
    xfer(`CVC_RANGE_OFS, 1, 32'h0000_0007); xfer(`CVC_RANGE_OFS, 0, 0); chk("rsv range", 32'h0000_0006, q);
    // hard resets then a soft one, each after moving wait states, select, prescaler and crystal enable away from reset
    for (int k = 0; k < 3; k++) begin
      xfer(`CVC_MEM_OFS, 1, 0); xfer(`CVC_CLK_OFS, 1, 32'h0003_00C1); wait_rdy; pulse(k);
      xfer(`CVC_MEM_OFS, 0, 0); chk("fws", k == 2 ? 32'h0 : 32'h5, q);
      xfer(`CVC_CLK_OFS, 0, 0); chk("sel psc", k == 2 ? 32'h0C1 : 32'h040, q & 32'h0000_01C3);
      chk("xtal en", 1'b1, xtal_osc_enable);
      chk("fast en", 1'b1, fast_osc_enable);
      chk("range kept", 2'h2, voltage_range_field);
      xfer(`CVC_FLASH_OFS, 1, 32'h0000_0000);
    end
    xfer(`CVC_CLK_OFS, 1, 32'h0003_0042); xfer(`CVC_CLK_OFS, 0, 0); chk("refused", 2'h1, q[1:0]);
    xtal_osc_ready <= 1;
    repeat (4) @(posedge clk);
    // align so the first crystal tick lands after the ready read
    @(negedge xtal_osc_clk);
    xfer(`CVC_CLK_OFS, 1, 32'h0003_0042); xfer(`CVC_CLK_OFS, 0, 0); chk("rdy low", 1'b0, q[13]);
    wait_rdy; xfer(`CVC_STAT_OFS, 0, 0); chk("active", 2'h2, q[1:0]);
    cnt(400); chk_in("sys xtal", 19, 21, ns);
    chk_in("pclk", 9, 11, np);
    chk_in("rtc", 39, 41, nr);
    xfer(`CVC_CLK_OFS, 1, 32'h0003_01C0); wait_rdy; cnt(2048); chk_in("sys psc7", 1, 3, ns);
    chk_in("rtc on fast", 203, 206, nr);
    xfer(`CVC_CLK_OFS, 1, 32'h0003_0001); wait_rdy; cnt(480); chk_in("sys ring", 39, 41, ns);
    chk_in("pclk ring", 19, 21, np);
    // flash access length in system clock pulses
    xfer(`CVC_MEM_OFS, 1, 32'h0000_0003);
    flash_req <= 1;
    @(posedge clk);
    flash_req <= 0;
    ns = 0; nw = 0;
    do begin
      @(posedge clk);
      ns += sys_clk_en; nw++;
    end while (flash_ack !== 1'b1 && nw < 500);
    chk_in("flash len", 3, 4, ns);
    // the pulse counter updates on the edge that ends the transfer, so let one edge pass
    xfer(`CVC_RST_OFS, 1, 32'h0000_0001); @(posedge clk); chk("prst", 32'h2, n_prst);
    xfer(`CVC_RST_OFS, 0, 0); chk("rst reads", 32'h0, q);
    xfer(12'h020, 0, 0); chk("unmapped", 1'b1, e);
    test_done;
  end

  // watchdog: the sequence needs well under 10000 cycles
  initial begin
    #3_000_000;
    n_errors++;
    test_done;
  end
endmodule : tb_top
